// >>> hdl/module_disable_pkg.sv
/*
  Package for the peripheral module disable bank.
  Holds the register map, implemented-bit masks, reset values and the
  carrier struct for the per-module off signals.
*/
package module_disable_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 12;

  // Byte addresses of the disable registers
  localparam logic [11:0] OFS_DISABLE_1 = 12'h0760;
  localparam logic [11:0] OFS_DISABLE_2 = 12'h0762;
  localparam logic [11:0] OFS_DISABLE_3 = 12'h0764;
  localparam logic [11:0] OFS_DISABLE_4 = 12'h0766;
  localparam logic [11:0] OFS_DISABLE_6 = 12'h076A;
  localparam logic [11:0] OFS_DISABLE_7 = 12'h076C;

  // Value after every reset
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // Implemented bits; the motor-control-only ones are masked separately
  localparam logic [15:0] MASK_DISABLE_1 = 16'hF8FB;
  localparam logic [15:0] MASK_DISABLE_1_MOTOR = 16'h0600;
  localparam logic [15:0] MASK_DISABLE_2 = 16'h0F0F;
  localparam logic [15:0] MASK_DISABLE_3 = 16'h0482;
  localparam logic [15:0] MASK_DISABLE_4 = 16'h000C;
  localparam logic [15:0] MASK_DISABLE_6 = 16'h0700;
  localparam logic [15:0] MASK_DISABLE_7 = 16'h0018;

  // Field positions
  localparam int unsigned POS_TIMER1 = 11;
  localparam int unsigned POS_ENCODER = 10;
  localparam int unsigned POS_PWM_BLOCK = 9;
  localparam int unsigned POS_FIRST_I2C = 7;
  localparam int unsigned POS_UART2 = 6;
  localparam int unsigned POS_UART1 = 5;
  localparam int unsigned POS_SPI2 = 4;
  localparam int unsigned POS_SPI1 = 3;
  localparam int unsigned POS_CAN = 1;
  localparam int unsigned POS_CONVERTER = 0;
  localparam int unsigned POS_CAPTURE1 = 8;
  localparam int unsigned POS_COMPARE1 = 0;
  localparam int unsigned POS_COMPARATOR = 10;
  localparam int unsigned POS_CRC = 7;
  localparam int unsigned POS_SECOND_I2C = 1;
  localparam int unsigned POS_REFCLK_OUT = 3;
  localparam int unsigned POS_CHARGE_MEAS = 2;
  localparam int unsigned POS_PWM_GEN1 = 8;
  localparam int unsigned POS_DMA = 4;
  localparam int unsigned POS_TRIGGER_GEN = 3;

  // Bus answer latency, in cycles, from accepted request to waitrequest low
  localparam int unsigned BUS_WAIT_CYCLES = 1;

  typedef struct packed {
    logic [4:0] timer_off;    // [4]=timer5 .. [0]=timer1
    logic encoder_off;
    logic pwm_block_off;
    logic first_i2c_off;
    logic uart2_off;
    logic uart1_off;
    logic spi_port2_off;
    logic spi_port1_off;
    logic can_off;
    logic converter_off;
    logic [3:0] capture_off;  // [3]=capture4 .. [0]=capture1
    logic [3:0] compare_off;  // [3]=compare4 .. [0]=compare1
    logic comparator_off;
    logic crc_off;
    logic second_i2c_off;
    logic refclk_out_off;
    logic charge_meas_off;
    logic [2:0] pwm_gen_off;  // [2]=gen3 .. [0]=gen1
    logic dma_channels_off;
    logic trigger_gen_off;
  } module_off_s;

endpackage

// >>> hdl/disable_reg.sv
/*
  One disable register: masked read-write storage.
  Assumes a one-cycle write strobe from the bus slave.
*/
`timescale 1ns/1ps
`default_nettype none
module disable_reg #(
  parameter logic [15:0] MASK = 16'h0000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Write port
  input wire logic i_we,
  input wire logic [15:0] i_wdata,
  // Stored value
  output logic [15:0] o_value
);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_value <= module_disable_pkg::RESET_VALUE;
    end else if (i_we) begin
      o_value <= i_wdata & MASK;
    end
  end

  a_mask_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_value & ~MASK) == 16'h0000)
    else $error("unimplemented disable bit set");

endmodule // disable_reg
`default_nettype wire

// >>> hdl/off_gate.sv
/*
  Clock gates for WIDTH disabled peripherals, one per bit.
  Assumes a glitch-free latch-based gate; here modelled as enable flop.
*/
`timescale 1ns/1ps
`default_nettype none
module off_gate #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Disable bits
  input wire logic [WIDTH-1:0] i_off,
  // Registered clock-enable, low while disabled
  output logic [WIDTH-1:0] o_clk_en
);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_en <= '1;
    end else begin
      o_clk_en <= ~i_off;
    end
  end

endmodule // off_gate
`default_nettype wire

// >>> hdl/module_disable_bank.sv
/*
  Peripheral module disable register bank with Avalon-MM slave.
  Assumes a synchronous master on i_clk that holds its request until
  waitrequest is seen low. Each set bit switches one peripheral off.
*/
// The implementer's own choice: the Avalon-MM slave port.
// Contract
// - Bit 10 of register 3 turns the comparator off when set.
// - Bit 7 of register 3 turns the CRC generator off when set.
// - Bit 1 of register 3 turns the second I2C controller off when set.
// - Unused bits of register 3 read zero and ignore writes.
// - Every register resets to 0000 so all modules start enabled.
// - Register 1 holds timer, encoder, PWM, I2C1, UART, SPI, CAN and converter bits.
// - Register 2 holds capture 4..1 in bits 11..8 and compare 4..1 in bits 3..0.
// - Register 4 implements only bits 3 and 2.
// - On motor variants register 6 holds PWM generator 3..1 off in bits 10..8.
// - Register 7 bit 4 turns all DMA channels off and bit 3 the trigger generator.
// - Without motor control, encoder, PWM and register 6 bits read zero.
// - Register 4 bit 3 turns the reference clock output off.
// - Register 4 bit 2 turns the charge time measurement off.
`timescale 1ns/1ps
`default_nettype none
module module_disable_bank #(
  parameter bit MOTOR_CONTROL = 1'b1,
  parameter int unsigned ADDR_W = module_disable_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [15:0] i_writedata,
  input wire logic [1:0] i_byteenable,
  output logic [15:0] o_readdata,
  output logic o_waitrequest,
  output logic [1:0] o_response,
  // Per-module off signals and clock enables
  output module_disable_pkg::module_off_s o_off,
  output logic [31:0] o_clk_en
);

  // Offsets need twelve address bits; any wider bus keeps the top bits zero
  if (ADDR_W < 12) begin : g_addr_check
    $error("ADDR_W must cover the register offsets");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } bus_state_e;

  localparam logic [15:0] MASK_1 = module_disable_pkg::MASK_DISABLE_1 |
    (MOTOR_CONTROL ? module_disable_pkg::MASK_DISABLE_1_MOTOR : 16'h0000);
  localparam logic [15:0] MASK_6 = MOTOR_CONTROL ? module_disable_pkg::MASK_DISABLE_6 : 16'h0000;

  bus_state_e state;
  bus_state_e next_state;
  logic [15:0] reg1, reg2, reg3, reg4, reg6, reg7;
  logic [15:0] lane_mask;
  logic [15:0] rd_mux;
  logic hit;
  logic [5:0] sel;
  logic [11:0] ofs;
  logic wr_go;
  module_disable_pkg::module_off_s next_off;
  logic [31:0] off_flat;

  assign ofs = i_address[11:0];
  assign lane_mask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  // Address decode
  always_comb begin
    sel = 6'h00;
    unique case (ofs)
      module_disable_pkg::OFS_DISABLE_1: sel = 6'h01;
      module_disable_pkg::OFS_DISABLE_2: sel = 6'h02;
      module_disable_pkg::OFS_DISABLE_3: sel = 6'h04;
      module_disable_pkg::OFS_DISABLE_4: sel = 6'h08;
      module_disable_pkg::OFS_DISABLE_6: sel = 6'h10;
      module_disable_pkg::OFS_DISABLE_7: sel = 6'h20;
      default: sel = 6'h00;
    endcase
  end
  // Shift instead of a part-select, which would be empty at ADDR_W of 12
  assign hit = (sel != 6'h00) && ((i_address >> 12) == '0);

  // One wait state; write commits on the edge waitrequest rises again
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (i_read || i_write) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Taken from the next state so the bus sees a flop, not decode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= (next_state != ST_DONE);
    end
  end
  assign wr_go = (state == ST_DONE) && i_write && hit;

  // Byte-enable merge so a partial write keeps the other lane
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  disable_reg #(.MASK(MASK_1)) u_reg1 (.i_clk(i_clk), .i_rst(i_rst),
    .i_we(wr_go && sel[0]), .i_wdata(merge(reg1, i_writedata, lane_mask)), .o_value(reg1));
  disable_reg #(.MASK(module_disable_pkg::MASK_DISABLE_2)) u_reg2 (.i_clk(i_clk), .i_rst(i_rst),
    .i_we(wr_go && sel[1]), .i_wdata(merge(reg2, i_writedata, lane_mask)), .o_value(reg2));
  disable_reg #(.MASK(module_disable_pkg::MASK_DISABLE_3)) u_reg3 (.i_clk(i_clk), .i_rst(i_rst),
    .i_we(wr_go && sel[2]), .i_wdata(merge(reg3, i_writedata, lane_mask)), .o_value(reg3));
  // register 4 bits 3 and 2
  disable_reg #(.MASK(module_disable_pkg::MASK_DISABLE_4)) u_reg4 (.i_clk(i_clk), .i_rst(i_rst),
    .i_we(wr_go && sel[3]), .i_wdata(merge(reg4, i_writedata, lane_mask)), .o_value(reg4));
  // register 6 empty without motor control
  disable_reg #(.MASK(MASK_6)) u_reg6 (.i_clk(i_clk), .i_rst(i_rst),
    .i_we(wr_go && sel[4]), .i_wdata(merge(reg6, i_writedata, lane_mask)), .o_value(reg6));
  // register 7 DMA and trigger bits
  disable_reg #(.MASK(module_disable_pkg::MASK_DISABLE_7)) u_reg7 (.i_clk(i_clk), .i_rst(i_rst),
    .i_we(wr_go && sel[5]), .i_wdata(merge(reg7, i_writedata, lane_mask)), .o_value(reg7));

  always_comb begin
    unique case (1'b1)
      sel[0]: rd_mux = reg1;
      sel[1]: rd_mux = reg2;
      sel[2]: rd_mux = reg3;
      sel[3]: rd_mux = reg4;
      sel[4]: rd_mux = reg6;
      sel[5]: rd_mux = reg7;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data and response captured with the request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readdata <= 16'h0000;
      o_response <= 2'b00;
    end else if (state == ST_IDLE && (i_read || i_write)) begin
      o_readdata <= (i_read && hit) ? rd_mux : 16'h0000;
      // Unmapped address answers DECODEERROR
      o_response <= hit ? 2'b00 : 2'b11;
    end
  end

  // Field extraction into off signals
  always_comb begin
    next_off = '0;
    next_off.timer_off = reg1[15:module_disable_pkg::POS_TIMER1];
    next_off.encoder_off = reg1[module_disable_pkg::POS_ENCODER];
    next_off.pwm_block_off = reg1[module_disable_pkg::POS_PWM_BLOCK];
    next_off.first_i2c_off = reg1[module_disable_pkg::POS_FIRST_I2C];
    next_off.uart2_off = reg1[module_disable_pkg::POS_UART2];
    next_off.uart1_off = reg1[module_disable_pkg::POS_UART1];
    next_off.spi_port2_off = reg1[module_disable_pkg::POS_SPI2];
    next_off.spi_port1_off = reg1[module_disable_pkg::POS_SPI1];
    next_off.can_off = reg1[module_disable_pkg::POS_CAN];
    next_off.converter_off = reg1[module_disable_pkg::POS_CONVERTER];
    next_off.capture_off = reg2[11:module_disable_pkg::POS_CAPTURE1];
    next_off.compare_off = reg2[3:module_disable_pkg::POS_COMPARE1];
    next_off.comparator_off = reg3[module_disable_pkg::POS_COMPARATOR];
    next_off.crc_off = reg3[module_disable_pkg::POS_CRC];
    next_off.second_i2c_off = reg3[module_disable_pkg::POS_SECOND_I2C];
    next_off.refclk_out_off = reg4[module_disable_pkg::POS_REFCLK_OUT];
    next_off.charge_meas_off = reg4[module_disable_pkg::POS_CHARGE_MEAS];
    next_off.pwm_gen_off = reg6[10:module_disable_pkg::POS_PWM_GEN1];
    next_off.dma_channels_off = reg7[module_disable_pkg::POS_DMA];
    next_off.trigger_gen_off = reg7[module_disable_pkg::POS_TRIGGER_GEN];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_off <= '0;
    end else begin
      o_off <= next_off;
    end
  end

  assign off_flat = next_off;

  off_gate #(.WIDTH(32)) u_gate (.i_clk(i_clk), .i_rst(i_rst), .i_off(off_flat), .o_clk_en(o_clk_en));

  a_comp_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[2] && i_byteenable[1] |=> ##1 o_off.comparator_off == $past(i_writedata[10], 2))
    else $error("comparator off does not follow write");
  a_crc_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[2] && i_byteenable[0] |=> ##1 o_off.crc_off == $past(i_writedata[7], 2))
    else $error("crc off does not follow write");
  a_i2c2_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.second_i2c_off == $past(reg3[1]))
    else $error("second i2c off mismatch");
  a_reg3_unused: assert property (@(posedge i_clk) disable iff (i_rst)
    (reg3 & 16'hFB7D) == 16'h0000)
    else $error("register 3 unused bit set");
  a_reset_zero: assert property (@(posedge i_clk)
    $fell(i_rst) |-> (reg1 | reg2 | reg3 | reg4 | reg6 | reg7) == 16'h0000)
    else $error("register not zero after reset");
  a_reg2_fields: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.capture_off == $past(reg2[11:8]) && o_off.compare_off == $past(reg2[3:0]))
    else $error("capture or compare mismatch");
  a_reg4_only: assert property (@(posedge i_clk) disable iff (i_rst)
    (reg4 & 16'hFFF3) == 16'h0000)
    else $error("register 4 unused bit set");
  a_dma_shared: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.dma_channels_off == $past(reg7[4]) && o_off.trigger_gen_off == $past(reg7[3]))
    else $error("dma or trigger mismatch");
  a_gate_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_clk_en ^ o_off) == 32'hFFFF_FFFF)
    else $error("clock enable not inverse of off bit");
  a_refclk_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[3] && i_byteenable[0] |=> ##1 o_off.refclk_out_off == $past(i_writedata[3], 2))
    else $error("refclk out off does not follow write");
  a_charge_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[3] && i_byteenable[0] |=> ##1 o_off.charge_meas_off == $past(i_writedata[2], 2))
    else $error("charge measurement off does not follow write");

  // Fixed bit numbers here, so a wrong field position shows up
  a_timer_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.timer_off == $past(reg1[15:11]))
    else $error("timer off mismatch");
  a_motor_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.encoder_off == $past(reg1[10]) && o_off.pwm_block_off == $past(reg1[9]))
    else $error("encoder or pwm block off mismatch");
  a_serial_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 {o_off.first_i2c_off, o_off.uart2_off, o_off.uart1_off} == $past(reg1[7:5])
      && {o_off.spi_port2_off, o_off.spi_port1_off} == $past(reg1[4:3]))
    else $error("serial port off mismatch");
  a_conv_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.can_off == $past(reg1[1]) && o_off.converter_off == $past(reg1[0]))
    else $error("can or converter off mismatch");
  a_pwm_gen_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_off.pwm_gen_off == $past(reg6[10:8]))
    else $error("pwm generator off mismatch");

  // Full-word writes keep only the implemented bits of registers 1, 2, 4, 6 and 7
  a_reg1_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[0] && i_byteenable == 2'b11 |=>
      reg1 == ($past(i_writedata) & (MOTOR_CONTROL ? 16'hFEFB : 16'hF8FB)))
    else $error("register 1 write mismatch");
  a_reg2_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[1] && i_byteenable == 2'b11 |=>
      reg2 == ($past(i_writedata) & 16'h0F0F))
    else $error("register 2 write mismatch");
  a_reg4_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[3] && i_byteenable == 2'b11 |=>
      reg4 == ($past(i_writedata) & 16'h000C))
    else $error("register 4 write mismatch");
  a_reg6_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[4] && i_byteenable == 2'b11 |=>
      reg6 == ($past(i_writedata) & (MOTOR_CONTROL ? 16'h0700 : 16'h0000)))
    else $error("register 6 write mismatch");
  a_reg7_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[5] && i_byteenable == 2'b11 |=>
      reg7 == ($past(i_writedata) & 16'h0018))
    else $error("register 7 write mismatch");
  a_basic_empty: assert property (@(posedge i_clk) disable iff (i_rst)
    !MOTOR_CONTROL |-> reg6 == 16'h0000 && reg1[10:9] == 2'b00)
    else $error("motor-only bit set in basic variant");
  // Partial writes must leave the other lane alone
  a_lane_low_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[0] && i_byteenable == 2'b01 |=> reg1[15:8] == $past(reg1[15:8]))
    else $error("upper lane changed by lower lane write");
  a_lane_high_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && sel[0] && i_byteenable == 2'b10 |=> reg1[7:0] == $past(reg1[7:0]))
    else $error("lower lane changed by upper lane write");
  a_reg3_read: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_IDLE && i_read && sel[2] |=> (o_readdata & 16'hFB7D) == 16'h0000)
    else $error("register 3 unused bit read as one");

  // Handshake: one wait state, answer held until the next request
  a_wait_one: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("waitrequest held too long");
  a_wait_release: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_IDLE && !i_read && !i_write |=> o_waitrequest)
    else $error("waitrequest low without a request");
  a_state_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot(state))
    else $error("bus state not one-hot");
  a_read_ok: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_IDLE && (i_read || i_write) && hit |=>
      o_response == 2'b00)
    else $error("mapped access not answered okay");
  a_resp_unmapped: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_IDLE && (i_read || i_write) && !hit |=>
      o_response == 2'b11 && o_readdata == 16'h0000)
    else $error("unmapped access not refused");
  a_unmapped_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_DONE && i_write && !hit |=> $stable(reg1) && $stable(reg2)
      && $stable(reg3) && $stable(reg4) && $stable(reg6) && $stable(reg7))
    else $error("unmapped write changed a register");
  a_resp_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_IDLE && !i_read && !i_write |=>
      $stable(o_readdata) && $stable(o_response))
    else $error("read data or response changed without a request");

  // Outputs must be at their idle values right after reset
  a_reset_outputs: assert property (@(posedge i_clk)
    $fell(i_rst) |-> o_off == '0 && o_clk_en == 32'hFFFF_FFFF && o_waitrequest)
    else $error("outputs not idle after reset");

  c_write_hit: cover property (@(posedge i_clk) wr_go);
  c_read_hit: cover property (@(posedge i_clk) state == ST_DONE && i_read && hit);
  c_unmapped: cover property (@(posedge i_clk) state == ST_DONE && !hit);
  c_partial_write: cover property (@(posedge i_clk) wr_go && i_byteenable != 2'b11);
  c_reset_release: cover property (@(posedge i_clk) $fell(i_rst));

endmodule // module_disable_bank
`default_nettype wire

// >>> bench/module_disable_bank_test.sv
/*
  Self-checking bench for the module disable bank.
  Assumes the design files are compiled first; drives the Avalon-MM
  port itself and runs a full and a reduced variant side by side.
*/
`timescale 1ns/1ps
`default_nettype none
module module_disable_bank_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [11:0] i_address = 12'h0000;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [15:0] i_writedata = 16'h0000;
  logic [1:0] i_byteenable = 2'b11;
  logic [15:0] o_readdata;
  logic o_waitrequest;
  logic [1:0] o_response;
  module_disable_pkg::module_off_s o_off;
  logic [31:0] o_clk_en;
  logic [15:0] basic_readdata;
  module_disable_pkg::module_off_s basic_off;
  int err_total = 0;
  int compares = 0;
  logic [11:0] addrs [6];
  logic [15:0] full_m [6];
  logic [15:0] basic_m [6];

  always #12.5 i_clk = ~i_clk;

  module_disable_bank #(.MOTOR_CONTROL(1'b1)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_response(o_response),
    .o_off(o_off), .o_clk_en(o_clk_en));
  // Reduced variant follows the same bus; its waitrequest is left to the full one
  module_disable_bank #(.MOTOR_CONTROL(1'b0)) dut_u_basic (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(basic_readdata), .o_waitrequest(), .o_response(), .o_off(basic_off), .o_clk_en());

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Entered just after a rising edge; request held until waitrequest low
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [1:0] be,
                      output logic [15:0] rd, output logic [15:0] rd_b, output logic [1:0] rsp);
    int n;
    n = 0;
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    i_byteenable <= be;
    // Sampled at the rising edge; only the watchdog ends a hung wait
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0);
    check("wait cycles", n, module_disable_pkg::BUS_WAIT_CYCLES + 1);
    rd = o_readdata;
    rd_b = basic_readdata;
    rsp = o_response;
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] r;
    logic [15:0] rb;
    logic [1:0] s;
    xfer(1'b1, a, d, be, r, rb, s);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp, input logic [15:0] exp_b,
                        input logic [1:0] exp_rsp);
    logic [15:0] r;
    logic [15:0] rb;
    logic [1:0] s;
    xfer(1'b0, a, 16'h0000, 2'b11, r, rb, s);
    check("readdata", {16'h0000, r}, {16'h0000, exp});
    check("basic readdata", {16'h0000, rb}, {16'h0000, exp_b});
    check("response", {30'h0, s}, {30'h0, exp_rsp});
  endtask

  // Off bits land one edge after the write; look mid-cycle
  task automatic off_chk(input module_disable_pkg::module_off_s exp);
    @(negedge i_clk);
    check("off", o_off, exp);
    check("clk_en", o_clk_en, ~exp);
    @(posedge i_clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], 16'h0000, 16'h0000, 2'b00);
    off_chk('0);
  endtask

  task automatic t_reg3_reg4();
    module_disable_pkg::module_off_s e;
    e = '0;
    wr(addrs[2], 16'hFFFF, 2'b11);
    rd_chk(addrs[2], 16'h0482, 16'h0482, 2'b00);
    e.comparator_off = 1'b1;
    e.crc_off = 1'b1;
    e.second_i2c_off = 1'b1;
    off_chk(e);
    wr(addrs[2], 16'h0400, 2'b11);
    e.crc_off = 1'b0;
    e.second_i2c_off = 1'b0;
    off_chk(e);
    wr(addrs[3], 16'hFFFF, 2'b11);
    rd_chk(addrs[3], 16'h000C, 16'h000C, 2'b00);
    e.refclk_out_off = 1'b1;
    e.charge_meas_off = 1'b1;
    off_chk(e);
    wr(addrs[3], 16'h0004, 2'b11);
    e.refclk_out_off = 1'b0;
    off_chk(e);
  endtask

  task automatic t_all_masks();
    module_disable_pkg::module_off_s e;
    e = '1;
    for (int i = 0; i < 6; i++) wr(addrs[i], 16'hFFFF, 2'b11);
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], full_m[i], basic_m[i], 2'b00);
    off_chk(e);
    e.encoder_off = 1'b0;
    e.pwm_block_off = 1'b0;
    e.pwm_gen_off = 3'b000;
    @(negedge i_clk);
    check("basic off", basic_off, e);
    @(posedge i_clk);
  endtask

  task automatic t_lanes();
    wr(addrs[0], 16'h0000, 2'b01);
    rd_chk(addrs[0], 16'hFE00, 16'hF800, 2'b00);
    wr(addrs[0], 16'h0000, 2'b10);
    rd_chk(addrs[0], 16'h0000, 16'h0000, 2'b00);
  endtask

  task automatic t_unmapped();
    wr(12'h0768, 16'hFFFF, 2'b11);
    rd_chk(12'h0768, 16'h0000, 16'h0000, 2'b11);
    rd_chk(addrs[1], 16'h0F0F, 16'h0F0F, 2'b00);
  endtask

  task automatic t_mid_reset();
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
  endtask

  initial begin
    addrs = '{module_disable_pkg::OFS_DISABLE_1, module_disable_pkg::OFS_DISABLE_2,
              module_disable_pkg::OFS_DISABLE_3, module_disable_pkg::OFS_DISABLE_4,
              module_disable_pkg::OFS_DISABLE_6, module_disable_pkg::OFS_DISABLE_7};
    full_m = '{16'hFEFB, 16'h0F0F, 16'h0482, 16'h000C, 16'h0700, 16'h0018};
    basic_m = '{16'hF8FB, 16'h0F0F, 16'h0482, 16'h000C, 16'h0000, 16'h0018};
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_reg3_reg4();
    t_all_masks();
    t_lanes();
    t_unmapped();
    t_mid_reset();
    wrap_up();
  end

  // Whole run needs about 130 cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    wrap_up();
  end
endmodule // module_disable_bank_test
`default_nettype wire
